// ==== hdl/cpsf_pkg.sv ====
// Package: constants, opcodes and carriers of the CPU pointer and status-flag block
package cpsf_pkg;

    // ********************************************************
    // Data memory geometry and bus
    // ********************************************************
    localparam int OFF_W = 8;
    localparam int APB_AW = 12;
    localparam int WORD_LSB = 2;

    // ********************************************************
    // Register index of each special location in sector 0
    // ********************************************************
    localparam logic [7:0] IDX_INDIRECT_PORT0 = 8'h00;
    localparam logic [7:0] IDX_SECTOR0_POINTER = 8'h01;
    localparam logic [7:0] IDX_INDIRECT_PORT1 = 8'h02;
    localparam logic [7:0] IDX_POINTER1_LOW = 8'h03;
    localparam logic [7:0] IDX_POINTER1_SECTOR = 8'h04;
    localparam logic [7:0] IDX_ACCUMULATOR = 8'h05;
    localparam logic [7:0] IDX_PROGRAM_COUNTER_LOW_BYTE = 8'h06;
    localparam logic [7:0] IDX_TABLE_POINTER_LOW = 8'h07;
    localparam logic [7:0] IDX_TABLE_READ_HIGH_LATCH = 8'h08;
    localparam logic [7:0] IDX_TABLE_POINTER_HIGH = 8'h09;
    localparam logic [7:0] IDX_STATUS = 8'h0A;
    localparam logic [7:0] IDX_INDIRECT_PORT2 = 8'h0C;
    localparam logic [7:0] IDX_POINTER2_LOW = 8'h0D;
    localparam logic [7:0] IDX_POINTER2_SECTOR = 8'h0E;

    // ********************************************************
    // Status register layout
    // ********************************************************
    localparam int ST_CARRY = 0;
    localparam int ST_NIBBLE_CARRY = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_SIGNED_WRAP = 3;
    localparam int ST_HALT_ENTERED = 4;
    localparam int ST_WATCHDOG_EXPIRY = 5;
    localparam int ST_CHAINED_NULL = 6;
    localparam int ST_SIGNED_LESS = 7;
    localparam logic [7:0] STATUS_SW_MASK = 8'hCF;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ********************************************************
    // Core command port
    // ********************************************************
    typedef enum logic [3:0] {
        CPSF_OP_NOP = 4'b0000,
        CPSF_OP_LOAD = 4'b0001,
        CPSF_OP_STORE = 4'b0010,
        CPSF_OP_ADD = 4'b0011,
        CPSF_OP_ADC = 4'b0100,
        CPSF_OP_SUB = 4'b0101,
        CPSF_OP_SBC = 4'b0110,
        CPSF_OP_AND = 4'b0111,
        CPSF_OP_OR = 4'b1000,
        CPSF_OP_XOR = 4'b1001,
        CPSF_OP_RLC = 4'b1010,
        CPSF_OP_INC = 4'b1011,
        CPSF_OP_DEC = 4'b1100,
        CPSF_OP_TABRD = 4'b1101,
        CPSF_OP_HALT = 4'b1110,
        CPSF_OP_WATCHDOG_KICK = 4'b1111
    } cpsf_op_type;

    typedef struct packed {
        logic valid;
        cpsf_op_type op;
        logic ext;
        logic [8:0] addr;
    } cpsf_cmd_type;

endpackage : cpsf_pkg

// ==== hdl/cpsf_core.sv ====
// CPU pointers, accumulator path, program counter low byte, table read and status flags
//
// What this block does
// - Pointers are real readable writable registers.
// - Indirect port access goes to pointed location.
// - Port zero reaches sector 0 only.
// - Ports one, two: sector from high byte.
// - Extended address upper part selects sector.
// - Memory transfers pass through the accumulator.
// - Low byte write jumps within page.
// - Low byte write inserts one dummy cycle.
// - Table read: high byte latched, low to destination.
// - Table pointers load, increment, decrement normally.
// - Status writes leave halt, watchdog flags.
// - Carry from add, no-borrow, rotate.
// - Nibble carry from low nibble carry.
// - Zero flag marks zero result.
// - Wrap flag: carry in differs carry out.
// - Signed-less flag is wrap XOR msb.
// - Halt flag: set by halt, kick clears.
// - Watchdog flag: set on expiry only.
// - Status is never pushed automatically.
// - Port register itself reads zero, ignores writes.
`timescale 1ns/100ps
`default_nettype none

module cpsf_core #(
    parameter int SECTORS = 2,
    parameter int SEC_W = 1,
    parameter int PC_W = 13
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cpsf_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cpsf_pkg::cpsf_cmd_type cmd,
    output logic cmd_ready,
    input wire logic watchdog_timer_expired,
    output logic [15:0] pm_addr,
    input wire logic [15:0] pm_data,
    output logic [7:0] acc,
    output logic [7:0] status,
    output logic [PC_W-1:0] pc,
    output logic dummy_cycle
);

    localparam int ADDR_W = SEC_W + cpsf_pkg::OFF_W;
    localparam int RAM_BYTES = SECTORS * 256;

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic [RAM_BYTES-1:0][7:0] ram;
        logic [7:0] sector0_pointer;
        logic [7:0] pointer1_low;
        logic [7:0] pointer1_sector;
        logic [7:0] pointer2_low;
        logic [7:0] pointer2_sector;
        logic [7:0] acc;
        logic [7:0] table_pointer_low;
        logic [7:0] table_pointer_high;
        logic [7:0] table_read_high_latch;
        logic [7:0] status;
        logic [PC_W-1:0] pc;
        logic dummy;
        logic fresh;
        logic [31:0] prdata;
    } cpsf_state_type;

    cpsf_state_type q;
    cpsf_state_type d;

    function automatic logic is_sfr(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        is_sfr = (a[ADDR_W-1:cpsf_pkg::OFF_W] == '0) && (a[cpsf_pkg::OFF_W-1:0] == idx);
    endfunction : is_sfr

    // One level of indirection; a pointer aimed at a port lands on the port itself
    function automatic logic [ADDR_W-1:0] resolve(input logic [ADDR_W-1:0] a);
        resolve = a;
        if (is_sfr(a, cpsf_pkg::IDX_INDIRECT_PORT0)) begin
            resolve = {{SEC_W{1'b0}}, q.sector0_pointer};
        end else if (is_sfr(a, cpsf_pkg::IDX_INDIRECT_PORT1)) begin
            resolve = {q.pointer1_sector[SEC_W-1:0], q.pointer1_low};
        end else if (is_sfr(a, cpsf_pkg::IDX_INDIRECT_PORT2)) begin
            resolve = {q.pointer2_sector[SEC_W-1:0], q.pointer2_low};
        end
    endfunction : resolve

    function automatic logic is_port(input logic [ADDR_W-1:0] a);
        is_port = is_sfr(a, cpsf_pkg::IDX_INDIRECT_PORT0)
            || is_sfr(a, cpsf_pkg::IDX_INDIRECT_PORT1)
            || is_sfr(a, cpsf_pkg::IDX_INDIRECT_PORT2);
    endfunction : is_port

    function automatic logic [7:0] rd(input logic [ADDR_W-1:0] a);
        rd = q.ram[a];
        if (is_port(a)) begin
            rd = cpsf_pkg::BYTE_ZERO;
        end else if (is_sfr(a, cpsf_pkg::IDX_SECTOR0_POINTER)) begin
            rd = q.sector0_pointer;
        end else if (is_sfr(a, cpsf_pkg::IDX_POINTER1_LOW)) begin
            rd = q.pointer1_low;
        end else if (is_sfr(a, cpsf_pkg::IDX_POINTER1_SECTOR)) begin
            rd = q.pointer1_sector;
        end else if (is_sfr(a, cpsf_pkg::IDX_POINTER2_LOW)) begin
            rd = q.pointer2_low;
        end else if (is_sfr(a, cpsf_pkg::IDX_POINTER2_SECTOR)) begin
            rd = q.pointer2_sector;
        end else if (is_sfr(a, cpsf_pkg::IDX_ACCUMULATOR)) begin
            rd = q.acc;
        end else if (is_sfr(a, cpsf_pkg::IDX_PROGRAM_COUNTER_LOW_BYTE)) begin
            rd = q.pc[7:0];
        end else if (is_sfr(a, cpsf_pkg::IDX_TABLE_POINTER_LOW)) begin
            rd = q.table_pointer_low;
        end else if (is_sfr(a, cpsf_pkg::IDX_TABLE_POINTER_HIGH)) begin
            rd = q.table_pointer_high;
        end else if (is_sfr(a, cpsf_pkg::IDX_TABLE_READ_HIGH_LATCH)) begin
            rd = q.table_read_high_latch;
        end else if (is_sfr(a, cpsf_pkg::IDX_STATUS)) begin
            rd = q.status;
        end
    endfunction : rd

    // ********************************************************
    // Next state
    // ********************************************************
    logic fire;
    logic apb_ok;
    logic apb_done;
    logic [ADDR_W-1:0] cmd_addr;
    logic [ADDR_W-1:0] apb_addr;
    logic [7:0] opnd;
    logic [7:0] b_op;
    logic cin;
    logic [4:0] nib;
    logic [7:0] low7;
    logic [8:0] sum;
    logic [7:0] res;
    logic arith;
    logic is_sub;
    logic wr_en;
    logic [ADDR_W-1:0] wr_a;
    logic [7:0] wr_v;

    always_comb begin
        d = q;
        d.dummy = 1'b0;
        fire = cmd.valid && !q.dummy;
        apb_ok = (paddr[cpsf_pkg::APB_AW-1:ADDR_W+cpsf_pkg::WORD_LSB] == '0)
            && (paddr[cpsf_pkg::WORD_LSB-1:0] == '0);
        apb_done = psel && penable && q.fresh && !fire;
        apb_addr = paddr[ADDR_W+cpsf_pkg::WORD_LSB-1:cpsf_pkg::WORD_LSB];
        // Plain instructions see sector 0 only; extended ones carry the sector
        cmd_addr = resolve({cmd.ext ? cmd.addr[ADDR_W-1:cpsf_pkg::OFF_W] : {SEC_W{1'b0}},
            cmd.addr[cpsf_pkg::OFF_W-1:0]});
        opnd = rd(cmd_addr);
        is_sub = (cmd.op == cpsf_pkg::CPSF_OP_SUB) || (cmd.op == cpsf_pkg::CPSF_OP_SBC);
        b_op = is_sub ? ~opnd : opnd;
        case (cmd.op)
            cpsf_pkg::CPSF_OP_SUB: cin = 1'b1;
            cpsf_pkg::CPSF_OP_ADC, cpsf_pkg::CPSF_OP_SBC: cin = q.status[cpsf_pkg::ST_CARRY];
            default: cin = 1'b0;
        endcase
        nib = {1'b0, q.acc[3:0]} + {1'b0, b_op[3:0]} + {4'h0, cin};
        low7 = {1'b0, q.acc[6:0]} + {1'b0, b_op[6:0]} + {7'h00, cin};
        sum = {1'b0, q.acc} + {1'b0, b_op} + {8'h00, cin};
        arith = 1'b0;
        res = sum[7:0];
        wr_en = 1'b0;
        wr_a = cmd_addr;
        wr_v = q.acc;

        if (fire) begin
            d.pc = q.pc + {{(PC_W-1){1'b0}}, 1'b1};
            case (cmd.op)
                cpsf_pkg::CPSF_OP_LOAD: begin
                    d.acc = opnd;
                end
                cpsf_pkg::CPSF_OP_STORE: begin
                    wr_en = 1'b1;
                end
                cpsf_pkg::CPSF_OP_ADD, cpsf_pkg::CPSF_OP_ADC,
                cpsf_pkg::CPSF_OP_SUB, cpsf_pkg::CPSF_OP_SBC: begin
                    arith = 1'b1;
                    d.acc = res;
                    d.status[cpsf_pkg::ST_CARRY] = sum[8];
                    d.status[cpsf_pkg::ST_NIBBLE_CARRY] = nib[4];
                    d.status[cpsf_pkg::ST_SIGNED_WRAP] = low7[7] ^ sum[8];
                    d.status[cpsf_pkg::ST_SIGNED_LESS] = (low7[7] ^ sum[8]) ^ res[7];
                end
                cpsf_pkg::CPSF_OP_AND: begin
                    res = q.acc & opnd;
                    d.acc = res;
                end
                cpsf_pkg::CPSF_OP_OR: begin
                    res = q.acc | opnd;
                    d.acc = res;
                end
                cpsf_pkg::CPSF_OP_XOR: begin
                    res = q.acc ^ opnd;
                    d.acc = res;
                end
                cpsf_pkg::CPSF_OP_RLC: begin
                    res = {q.acc[6:0], q.status[cpsf_pkg::ST_CARRY]};
                    d.acc = res;
                    d.status[cpsf_pkg::ST_CARRY] = q.acc[7];
                end
                cpsf_pkg::CPSF_OP_INC: begin
                    res = opnd + 8'h01;
                    wr_en = 1'b1;
                    wr_v = res;
                end
                cpsf_pkg::CPSF_OP_DEC: begin
                    res = opnd - 8'h01;
                    wr_en = 1'b1;
                    wr_v = res;
                end
                cpsf_pkg::CPSF_OP_TABRD: begin
                    d.table_read_high_latch = pm_data[15:8];
                    wr_en = 1'b1;
                    wr_v = pm_data[7:0];
                end
                cpsf_pkg::CPSF_OP_HALT: begin
                    d.status[cpsf_pkg::ST_HALT_ENTERED] = 1'b1;
                    d.status[cpsf_pkg::ST_WATCHDOG_EXPIRY] = 1'b0;
                end
                cpsf_pkg::CPSF_OP_WATCHDOG_KICK: begin
                    d.status[cpsf_pkg::ST_HALT_ENTERED] = 1'b0;
                    d.status[cpsf_pkg::ST_WATCHDOG_EXPIRY] = 1'b0;
                end
                default: begin
                end
            endcase
            // Rotate, moves and table reads leave the zero flag alone
            if (arith || (cmd.op == cpsf_pkg::CPSF_OP_AND) || (cmd.op == cpsf_pkg::CPSF_OP_OR)
                || (cmd.op == cpsf_pkg::CPSF_OP_XOR) || (cmd.op == cpsf_pkg::CPSF_OP_INC)
                || (cmd.op == cpsf_pkg::CPSF_OP_DEC)) begin
                d.status[cpsf_pkg::ST_ZERO] = (res == cpsf_pkg::BYTE_ZERO);
            end
            if (cmd.op == cpsf_pkg::CPSF_OP_SUB) begin
                d.status[cpsf_pkg::ST_CHAINED_NULL] = (res == cpsf_pkg::BYTE_ZERO);
            end else if (cmd.op == cpsf_pkg::CPSF_OP_SBC) begin
                d.status[cpsf_pkg::ST_CHAINED_NULL] =
                    q.status[cpsf_pkg::ST_CHAINED_NULL] && (res == cpsf_pkg::BYTE_ZERO);
            end
        end else if (apb_done && pwrite && apb_ok) begin
            // Software reaches data memory only in cycles the core leaves free
            wr_en = 1'b1;
            wr_a = resolve(apb_addr);
            wr_v = pwdata[7:0];
        end

        // Single write port; a destination that is a port itself is dropped
        if (wr_en && !is_port(wr_a)) begin
            if (is_sfr(wr_a, cpsf_pkg::IDX_SECTOR0_POINTER)) begin
                d.sector0_pointer = wr_v;
            end else if (is_sfr(wr_a, cpsf_pkg::IDX_POINTER1_LOW)) begin
                d.pointer1_low = wr_v;
            end else if (is_sfr(wr_a, cpsf_pkg::IDX_POINTER1_SECTOR)) begin
                d.pointer1_sector = wr_v;
            end else if (is_sfr(wr_a, cpsf_pkg::IDX_POINTER2_LOW)) begin
                d.pointer2_low = wr_v;
            end else if (is_sfr(wr_a, cpsf_pkg::IDX_POINTER2_SECTOR)) begin
                d.pointer2_sector = wr_v;
            end else if (is_sfr(wr_a, cpsf_pkg::IDX_ACCUMULATOR)) begin
                d.acc = wr_v;
            end else if (is_sfr(wr_a, cpsf_pkg::IDX_PROGRAM_COUNTER_LOW_BYTE)) begin
                d.pc = {q.pc[PC_W-1:8], wr_v};
                d.dummy = 1'b1;
            end else if (is_sfr(wr_a, cpsf_pkg::IDX_TABLE_POINTER_LOW)) begin
                d.table_pointer_low = wr_v;
            end else if (is_sfr(wr_a, cpsf_pkg::IDX_TABLE_POINTER_HIGH)) begin
                d.table_pointer_high = wr_v;
            end else if (is_sfr(wr_a, cpsf_pkg::IDX_TABLE_READ_HIGH_LATCH)) begin
                d.table_read_high_latch = wr_v;
            end else if (is_sfr(wr_a, cpsf_pkg::IDX_STATUS)) begin
                d.status = (wr_v & cpsf_pkg::STATUS_SW_MASK)
                    | (d.status & ~cpsf_pkg::STATUS_SW_MASK);
            end else begin
                d.ram[wr_a] = wr_v;
            end
        end

        // Expiry is applied last so it wins over a same-cycle halt or kick
        if (watchdog_timer_expired) begin
            d.status[cpsf_pkg::ST_WATCHDOG_EXPIRY] = 1'b1;
        end

        // Read data is sampled in a core-free cycle and offered one cycle later
        d.fresh = psel && !fire;
        d.prdata = {24'h00_0000, apb_ok ? rd(resolve(apb_addr)) : cpsf_pkg::BYTE_ZERO};
    end

    // ********************************************************
    // Registers
    // ********************************************************
    // Nothing here stacks the status on calls or interrupts; software must save it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.status <= cpsf_pkg::STATUS_RESET;
        end else begin
            q <= d;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign cmd_ready = !q.dummy;
    assign pready = apb_done;
    assign pslverr = apb_done && !apb_ok;
    assign prdata = q.prdata;
    assign pm_addr = {q.table_pointer_high, q.table_pointer_low};
    assign acc = q.acc;
    assign status = q.status;
    assign pc = q.pc;
    assign dummy_cycle = q.dummy;

endmodule : cpsf_core

`default_nettype wire

// ==== bench/cpsf_core_monitor.sv ====
// Port checker of the pointer and status-flag block, bound to the core
`timescale 1ns/100ps
`default_nettype none
module cpsf_core_monitor #(
    parameter int PC_W = 13
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cpsf_pkg::APB_AW-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire cpsf_pkg::cpsf_cmd_type cmd,
    input wire logic cmd_ready,
    input wire logic watchdog_timer_expired,
    input wire logic [15:0] pm_data,
    input wire logic [7:0] acc,
    input wire logic [7:0] status,
    input wire logic [PC_W-1:0] pc,
    input wire logic dummy_cycle
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic take;
    logic pcl_wr;
    logic sys_op;
    logic wte;
    assign wte = watchdog_timer_expired;
    assign take = cmd.valid && cmd_ready;
    assign sys_op = take
        && cmd.op inside {cpsf_pkg::CPSF_OP_HALT, cpsf_pkg::CPSF_OP_WATCHDOG_KICK};
    assign pcl_wr = take && cmd.op == cpsf_pkg::CPSF_OP_STORE && !cmd.ext && cmd.addr[7:0] == 8'h06;

    // ****************************************
    // Assertions
    // ****************************************
    a_pcl_dummy_cycle: assert property (pcl_wr |=> dummy_cycle && !cmd_ready ##1 cmd_ready)
        else $error("no single dummy cycle after a low byte write");
    a_pcl_page_jump: assert property (pcl_wr |=> pc == {$past(pc[PC_W-1:8]), $past(acc)})
        else $error("low byte write left the current page");
    a_halt_sets_flag: assert property (take && cmd.op == cpsf_pkg::CPSF_OP_HALT && !wte
        |=> status[5:4] == 2'b01) else $error("halt did not set only the halt flag");
    a_kick_clears_flags: assert property (take && cmd.op == cpsf_pkg::CPSF_OP_WATCHDOG_KICK
        && !wte |=> status[5:4] == 2'b00) else $error("kick did not clear both flags");
    a_expiry_sets_flag: assert property (wte |=> status[5])
        else $error("expiry did not set its flag");
    a_halt_flag_holds: assert property (!sys_op |=> $stable(status[4]))
        else $error("halt flag moved without halt or kick");
    a_expiry_flag_holds: assert property (!sys_op && !wte |=> $stable(status[5]))
        else $error("expiry flag moved without cause");
    a_table_low_dest: assert property (take && cmd.op == cpsf_pkg::CPSF_OP_TABRD && !cmd.ext
        && cmd.addr[7:0] == 8'h05 |=> acc == $past(pm_data[7:0]))
        else $error("table low byte not delivered");
    a_bad_addr_error: assert property (psel && penable && pready
        && (paddr[11] || paddr[1:0] != 2'b00) |-> pslverr) else $error("bad address not refused");
    c_pcl_write: cover property (pcl_wr);
    c_table_read: cover property (take && cmd.op == cpsf_pkg::CPSF_OP_TABRD);
    c_both_flags: cover property (status[5] && status[4]);
endmodule : cpsf_core_monitor

bind cpsf_core cpsf_core_monitor #(.PC_W(PC_W)) mon_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .cmd(cmd), .cmd_ready(cmd_ready), .pm_data(pm_data), .acc(acc),
    .watchdog_timer_expired(watchdog_timer_expired), .status(status), .pc(pc),
    .dummy_cycle(dummy_cycle));
`default_nettype wire

// ==== bench/cpsf_core_tb.sv ====
// Self-checking bench of the pointer and status-flag block
`timescale 1ns/100ps
`default_nettype none
module cpsf_core_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic watchdog_timer_expired = 1'b0;
    logic [15:0] pm_data = 16'h0000;
    cpsf_pkg::cpsf_cmd_type cmd = '0;
    logic [31:0] prdata;
    logic pready, pslverr, cmd_ready, dummy_cycle;
    logic [15:0] pm_addr;
    logic [7:0] acc, status;
    logic [12:0] pc;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;

    cpsf_core #(.SECTORS(2), .SEC_W(1), .PC_W(13)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd(cmd), .cmd_ready(cmd_ready),
        .watchdog_timer_expired(watchdog_timer_expired), .pm_addr(pm_addr), .pm_data(pm_data),
        .acc(acc), .status(status), .pc(pc), .dummy_cycle(dummy_cycle));

    always #5 pclk = ~pclk;
    // Table memory: high and low bytes differ so a swapped latch shows up
    always @(posedge pclk) begin
        pm_data <= {pm_addr[7:0], pm_addr[15:8] ^ 8'h3C};
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            $display("mismatch at %0t: run too long", $time);
            give_verdict();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // Master waits up to 64 cycles for pready; pready and the answer are taken at one rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
        output logic [7:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(16'(n < 64), 16'h0001, "pready wait");
        chk(16'(|prdata[31:8]), 16'h0000, "read upper bits");
        @(negedge pclk);
    endtask : apb
    task automatic wr(input logic [8:0] idx, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(1'b1, {1'b0, idx, 2'b00}, d, r, e);
    endtask : wr
    task automatic rd(input logic [8:0] idx, input logic [7:0] x, input string what);
        logic [7:0] r;
        logic e;
        apb(1'b0, {1'b0, idx, 2'b00}, 8'h00, r, e);
        chk(16'(r), 16'(x), what);
    endtask : rd
    task automatic op(input cpsf_pkg::cpsf_op_type o, input logic x, input logic [8:0] a);
        @(posedge pclk);
        cmd <= '{1'b1, o, x, a};
        @(posedge pclk);
        cmd.valid <= 1'b0;
        @(negedge pclk);
    endtask : op
    function automatic logic [7:0] ar(cpsf_pkg::cpsf_op_type o, logic [7:0] a, m, pre);
        logic sb, ci;
        logic [7:0] b, q, e;
        logic [8:0] s;
        logic [4:0] n;
        sb = o == cpsf_pkg::CPSF_OP_SUB || o == cpsf_pkg::CPSF_OP_SBC;
        ci = o == cpsf_pkg::CPSF_OP_SUB || (o != cpsf_pkg::CPSF_OP_ADD && pre[0]);
        b = sb ? ~m : m;
        s = a + b + ci;
        n = a[3:0] + b[3:0] + ci;
        q = a[6:0] + b[6:0] + ci;
        e = pre;
        e[0] = s[8];
        e[1] = n[4];
        e[2] = s[7:0] == 8'h00;
        e[3] = q[7] ^ s[8];
        e[7] = e[3] ^ s[7];
        if (sb) e[6] = e[2] && (o == cpsf_pkg::CPSF_OP_SUB || pre[6]);
        return e;
    endfunction : ar
    task automatic fl(input cpsf_pkg::cpsf_op_type o, input logic [7:0] a, m, pre, x);
        wr(9'h005, a);
        wr(9'h043, m);
        wr(9'h00A, pre);
        op(o, 1'b0, 9'h043);
        chk(16'(status & cpsf_pkg::STATUS_SW_MASK), 16'(x & cpsf_pkg::STATUS_SW_MASK), "flags");
    endtask : fl

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_pointers;
        wr(9'h001, 8'h40);
        rd(9'h001, 8'h40, "pointer0 storage");
        wr(9'h000, 8'hA5);
        rd(9'h040, 8'hA5, "port0 redirect");
        wr(9'h003, 8'hF0);
        wr(9'h004, 8'h01);
        wr(9'h002, 8'h3C);
        rd(9'h1F0, 8'h3C, "port1 sector");
        wr(9'h001, 8'hF0);
        wr(9'h000, 8'h77);
        rd(9'h0F0, 8'h77, "port0 sector0");
        rd(9'h1F0, 8'h3C, "sector1 untouched");
        op(cpsf_pkg::CPSF_OP_LOAD, 1'b1, 9'h1F0);
        chk(16'(acc), 16'h003C, "extended load");
        op(cpsf_pkg::CPSF_OP_STORE, 1'b0, 9'h041);
        rd(9'h041, 8'h3C, "move via acc");
        wr(9'h001, 8'h00);
        wr(9'h000, 8'h55);
        rd(9'h000, 8'h00, "port self read");
        rd(9'h001, 8'h00, "port self write");
    endtask : t_pointers
    task automatic t_pcl;
        logic [12:0] p;
        repeat (260) op(cpsf_pkg::CPSF_OP_NOP, 1'b0, 9'h000);
        wr(9'h005, 8'h5A);
        p = pc;
        @(posedge pclk);
        cmd <= '{1'b1, cpsf_pkg::CPSF_OP_STORE, 1'b0, 9'h006};
        @(posedge pclk);
        cmd <= '{1'b1, cpsf_pkg::CPSF_OP_LOAD, 1'b0, 9'h041};
        @(negedge pclk);
        chk(16'({dummy_cycle, cmd_ready}), 16'h0002, "dummy cycle");
        chk(16'(pc), 16'({p[12:8], 8'h5A}), "page jump");
        @(posedge pclk);
        @(posedge pclk);
        cmd.valid <= 1'b0;
        @(negedge pclk);
        chk(16'(acc), 16'h003C, "op after dummy");
        chk(16'(pc), 16'({p[12:8], 8'h5B}), "op in dummy refused");
    endtask : t_pcl
    task automatic t_table;
        wr(9'h007, 8'h34);
        wr(9'h009, 8'h12);
        chk(pm_addr, 16'h1234, "table pointers");
        op(cpsf_pkg::CPSF_OP_TABRD, 1'b0, 9'h042);
        rd(9'h008, 8'h34, "table high latch");
        rd(9'h042, 8'h2E, "table low dest");
        op(cpsf_pkg::CPSF_OP_INC, 1'b0, 9'h007);
        op(cpsf_pkg::CPSF_OP_DEC, 1'b0, 9'h009);
        chk(pm_addr, 16'h1135, "pointer inc dec");
        op(cpsf_pkg::CPSF_OP_TABRD, 1'b0, 9'h005);
        chk(16'(acc), 16'h002D, "table low to acc");
    endtask : t_table
    task automatic t_flags;
        fl(cpsf_pkg::CPSF_OP_ADD, 8'h7F, 8'h01, 8'h00,
            ar(cpsf_pkg::CPSF_OP_ADD, 8'h7F, 8'h01, 8'h00));
        fl(cpsf_pkg::CPSF_OP_ADD, 8'hF8, 8'h08, 8'h00, 8'h07);
        fl(cpsf_pkg::CPSF_OP_ADC, 8'h0E, 8'h01, 8'h01, 8'h02);
        fl(cpsf_pkg::CPSF_OP_SUB, 8'h05, 8'h05, 8'h00, 8'h47);
        fl(cpsf_pkg::CPSF_OP_SUB, 8'h10, 8'h20, 8'h00,
            ar(cpsf_pkg::CPSF_OP_SUB, 8'h10, 8'h20, 8'h00));
        fl(cpsf_pkg::CPSF_OP_SBC, 8'h05, 8'h05, 8'h41, 8'h47);
        fl(cpsf_pkg::CPSF_OP_SBC, 8'h05, 8'h05, 8'h40,
            ar(cpsf_pkg::CPSF_OP_SBC, 8'h05, 8'h05, 8'h40));
        fl(cpsf_pkg::CPSF_OP_AND, 8'h0F, 8'hF0, 8'h00, 8'h04);
        fl(cpsf_pkg::CPSF_OP_OR, 8'h01, 8'h00, 8'h04, 8'h00);
        fl(cpsf_pkg::CPSF_OP_XOR, 8'h5A, 8'h5A, 8'h00, 8'h04);
        fl(cpsf_pkg::CPSF_OP_INC, 8'h00, 8'hFF, 8'h00, 8'h04);
        fl(cpsf_pkg::CPSF_OP_DEC, 8'h00, 8'h02, 8'h04, 8'h00);
        fl(cpsf_pkg::CPSF_OP_RLC, 8'h80, 8'h80, 8'h00, 8'h01);
    endtask : t_flags
    task automatic t_system;
        logic [7:0] r;
        logic e;
        op(cpsf_pkg::CPSF_OP_HALT, 1'b0, 9'h000);
        chk(16'(status[5:4]), 16'h0001, "halt flag");
        @(posedge pclk);
        watchdog_timer_expired <= 1'b1;
        @(posedge pclk);
        watchdog_timer_expired <= 1'b0;
        @(negedge pclk);
        chk(16'(status[5:4]), 16'h0003, "expiry flag");
        wr(9'h00A, 8'h00);
        rd(9'h00A, 8'h30, "status write keeps");
        op(cpsf_pkg::CPSF_OP_HALT, 1'b0, 9'h000);
        chk(16'(status[5:4]), 16'h0001, "halt clears expiry");
        op(cpsf_pkg::CPSF_OP_WATCHDOG_KICK, 1'b0, 9'h000);
        chk(16'(status[5:4]), 16'h0000, "kick clears");
        apb(1'b0, 12'h800, 8'h00, r, e);
        chk({7'h00, e, r}, 16'h0100, "unmapped read");
        apb(1'b1, 12'h006, 8'h11, r, e);
        chk(16'(e), 16'h0001, "unaligned write");
    endtask : t_system

    task automatic give_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_pointers();
        t_pcl();
        t_table();
        t_flags();
        t_system();
        give_verdict();
    end
endmodule : cpsf_core_tb
`default_nettype wire
